// File: hw/adcic_pkg.sv
package adcic_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int AUTO_PERIOD_NS = 1000;
    localparam int TURBO_PERIOD_NS = 320;
    localparam int AUTO_CYC = (AUTO_PERIOD_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int TURBO_CYC = (TURBO_PERIOD_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // ---------------------------------------------------------------
    // command bytes
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_RD_SINGLE = 8'h10;
    localparam logic [7:0] OP_RD_BLOCK = 8'h30;
    localparam logic [7:0] OP_WR_SINGLE = 8'h08;
    localparam logic [7:0] OP_SET_BITS = 8'h18;
    localparam logic [7:0] OP_CLR_BITS = 8'h20;
    localparam logic [7:0] OP_WR_BLOCK = 8'h28;
    localparam logic [7:0] OP_NONE = 8'hFF;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [7:0] GC_RESET = 8'h06;
    localparam logic [7:0] GC_READDR = 8'h04;

    // ---------------------------------------------------------------
    // register map and fields
    // ---------------------------------------------------------------
    localparam logic [5:0] A_STATUS = 6'h00;
    localparam logic [5:0] A_GENCFG = 6'h01;
    localparam logic [5:0] A_OPMODE = 6'h04;
    localparam logic [5:0] A_SEQCFG = 6'h10;
    localparam logic [5:0] A_MANUAL_CH = 6'h11;
    localparam logic [5:0] A_SEQ_MASK = 6'h12;
    localparam logic [5:0] A_ALERT_SEL = 6'h14;
    localparam logic [5:0] A_EVT_FLAG = 6'h18;
    localparam logic [1:0] OFS_HIGH_TH = 2'h1;
    localparam logic [1:0] OFS_LOW_TH = 2'h3;
    localparam logic [63:0] REG_IMPL = 64'hFFFF_FFFF_55D7_2ABF;
    localparam int B_PWR_CYCLE = 0;
    localparam int B_SELF_RST = 0;
    localparam int B_CONV_LO = 5;
    localparam int B_RUN = 4;
    localparam logic [1:0] CM_MANUAL = 2'h0;
    localparam logic [1:0] CM_AUTO = 2'h1;
    localparam logic [1:0] CM_TURBO = 2'h2;
    localparam logic [1:0] SM_SEQ = 2'h1;
    localparam logic [7:0] RST_STATUS = 8'h01;
    localparam logic [7:0] RST_HIGH_TH = 8'hFF;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RX = 5'b00010,
        S_ACK = 5'b00100,
        S_TX = 5'b01000,
        S_TACK = 5'b10000
    } adcic_state_t;

    typedef struct packed {
        logic start;
        logic [2:0] ch;
    } adcic_conv_t;

    typedef struct packed {
        logic done;
        logic [11:0] data;
    } adcic_res_t;

endpackage

// File: hw/adcic_top.sv
`timescale 1ns/1ps
// Function
// - power-up strap sets address, flag power cycle
// - general call reset, self-reset bit reset device
// - manual: convert at address ack and at ack after each second byte read
// - auto-sequence: next masked channel, ascending order
// - run bit starts or stops channel sequencing
// - autonomous: host first start, timer afterward
// - autonomous: threshold crossing drives alert output
// - turbo: compare only, no result data
// - turbo: sequencer advances after each comparison
// - decode single and block read opcodes
// - decode write, set, clear, block write opcodes
// - single read repeats same register value
// - block read returns successive registers
// - unimplemented or beyond-end reads return zero
// - single write stores data byte at address, except status, where it clears the bits written as one
// - set and clear affect only one bits
// - reset leaves device in manual mode
// - block write ignores unimplemented or beyond end
module adcic_top
    import adcic_pkg::*;
#(
    parameter logic [6:0] ADDR_BASE = 7'h10
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address strap
    input wire logic [2:0] addr_strap,
    // converter
    output adcic_conv_t conv_req,
    input wire adcic_res_t conv_res,
    // alert
    output logic alert_out
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [1:0] scl_sy_ff, sda_sy_ff;
    logic [2:0] strap_m_ff, strap_s_ff;
    logic scl_d_ff, sda_d_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sy_ff <= 2'h3;
            sda_sy_ff <= 2'h3;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            strap_m_ff <= 3'h0;
            strap_s_ff <= 3'h0;
        end
        else
        begin
            scl_sy_ff <= {scl_sy_ff[0], scl_in};
            sda_sy_ff <= {sda_sy_ff[0], sda_in};
            scl_d_ff <= scl_sy_ff[1];
            sda_d_ff <= sda_sy_ff[1];
            strap_m_ff <= addr_strap;
            strap_s_ff <= strap_m_ff;
        end
    end

    wire scl = scl_sy_ff[1];
    wire sda = sda_sy_ff[1];
    wire scl_rise = scl & ~scl_d_ff;
    wire scl_fall = ~scl & scl_d_ff;
    wire start_c = scl & scl_d_ff & sda_d_ff & ~sda;
    wire stop_c = scl & scl_d_ff & ~sda_d_ff & sda;

    // ---------------------------------------------------------------
    // declarations shared by the sections below
    // ---------------------------------------------------------------
    logic [7:0] regs_ff [0:63];
    adcic_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [1:0] byte_idx_ff;
    logic [7:0] sh_ff, tx_ff, op_ff;
    logic [6:0] ptr_ff, my_addr_ff;
    logic gc_ff, reading_ff, rd_reg_ff, rd_blk_ff, rd_cnt_ff, nack_ff;
    logic soft_rst_ff, readdr_ff, addr_ok_ff, sda_out_ff;
    logic [1:0] eval_cnt_ff;
    logic [11:0] result_ff;
    logic [2:0] seq_ch_ff;
    logic arm_ff, alert_ff;
    logic [7:0] tmr_ff;
    adcic_conv_t conv_ff;

    wire [1:0] conv_mode = regs_ff[A_OPMODE][B_CONV_LO +: 2];
    wire seq_on = regs_ff[A_SEQCFG][1:0] == SM_SEQ;
    wire run = regs_ff[A_SEQCFG][B_RUN];
    wire [7:0] seq_mask = regs_ff[A_SEQ_MASK];

    function automatic logic [7:0] rst_val(input int i);
        logic [1:0] lo;
        lo = 2'(i);
        if (i == int'(A_STATUS))
            return RST_STATUS;
        if (i >= 32 && lo == OFS_HIGH_TH)
            return RST_HIGH_TH;
        return 8'h00;
    endfunction

    function automatic logic [7:0] rd_val(input logic [6:0] p);
        logic [7:0] v;
        v = 8'h00;
        if (!p[6] && REG_IMPL[p[5:0]])
            v = regs_ff[p[5:0]];
        return v;
    endfunction

    function automatic logic [2:0] nxt_chan(input logic [2:0] cur,
                                             input logic [7:0] m);
        logic [2:0] r, c;
        logic found;
        r = cur;
        found = 1'b0;
        for (int i = 1; i <= 8; i++)
        begin
            c = 3'(int'(cur) + i);
            if (!found && m[c])
            begin
                r = c;
                found = 1'b1;
            end
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // address evaluation
    // ---------------------------------------------------------------
    // the strap settles through its synchroniser before it is taken
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_ok_ff <= 1'b0;
            eval_cnt_ff <= 2'h0;
            my_addr_ff <= 7'h00;
        end
        else if (soft_rst_ff || readdr_ff)
        begin
            addr_ok_ff <= 1'b0;
            eval_cnt_ff <= 2'h0;
        end
        else if (!addr_ok_ff)
        begin
            eval_cnt_ff <= eval_cnt_ff + 2'h1;
            if (eval_cnt_ff == STRAP_SETTLE)
            begin
                my_addr_ff <= ADDR_BASE + {4'h0, strap_s_ff};
                addr_ok_ff <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // serial command engine
    // ---------------------------------------------------------------
    wire byte_done = state_ff == S_RX && scl_fall && bit_cnt_ff == 4'h8;
    wire is_gc = sh_ff == GC_ADDR;
    wire addr_hit = addr_ok_ff && sh_ff[7:1] == my_addr_ff;
    wire ack_ok = byte_idx_ff != 2'h0 || addr_hit || is_gc;
    wire op_valid = sh_ff == OP_RD_SINGLE || sh_ff == OP_RD_BLOCK ||
                    sh_ff == OP_WR_SINGLE || sh_ff == OP_SET_BITS ||
                    sh_ff == OP_CLR_BITS || sh_ff == OP_WR_BLOCK;
    wire op_write = op_ff == OP_WR_SINGLE || op_ff == OP_SET_BITS ||
                    op_ff == OP_CLR_BITS || op_ff == OP_WR_BLOCK;
    wire wr_hit = byte_done && !gc_ff && byte_idx_ff == 2'h3 &&
                  op_write && !ptr_ff[6] && REG_IMPL[ptr_ff[5:0]];
    wire load_tx = (state_ff == S_ACK && scl_fall && reading_ff) ||
                   (state_ff == S_TACK && scl_fall && !nack_ff);
    wire conv_rd = reading_ff && !rd_reg_ff;
    wire host_start = conv_rd && scl_fall &&
                      ((state_ff == S_ACK && byte_idx_ff == 2'h1) ||
                       (state_ff == S_TACK && !rd_cnt_ff));
    wire [6:0] ptr_inc = ptr_ff[6] ? ptr_ff : ptr_ff + 7'h01;
    logic [7:0] tx_next, wr_val;

    always_comb
    begin
        if (rd_reg_ff)
            tx_next = rd_val(ptr_ff);
        else if (conv_mode == CM_TURBO)
            tx_next = 8'h00;
        else if (!rd_cnt_ff)
            tx_next = result_ff[11:4];
        else
            tx_next = {result_ff[3:0], 1'b0, conv_ff.ch};
    end

    always_comb
    begin
        wr_val = sh_ff;
        if (op_ff == OP_SET_BITS)
            wr_val = regs_ff[ptr_ff[5:0]] | sh_ff;
        else if (op_ff == OP_CLR_BITS)
            wr_val = regs_ff[ptr_ff[5:0]] & ~sh_ff;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= S_IDLE;
            bit_cnt_ff <= 4'h0;
            byte_idx_ff <= 2'h0;
            sh_ff <= 8'h00;
            tx_ff <= 8'h00;
            op_ff <= OP_NONE;
            ptr_ff <= 7'h00;
            gc_ff <= 1'b0;
            reading_ff <= 1'b0;
            rd_reg_ff <= 1'b0;
            rd_blk_ff <= 1'b0;
            rd_cnt_ff <= 1'b0;
            nack_ff <= 1'b0;
            sda_oe <= 1'b0;
            sda_out_ff <= 1'b0;
        end
        else if (soft_rst_ff || start_c || stop_c)
        begin
            state_ff <= start_c ? S_RX : S_IDLE;
            bit_cnt_ff <= 4'h0;
            byte_idx_ff <= 2'h0;
            sda_oe <= 1'b0;
            if (soft_rst_ff)
                op_ff <= OP_NONE;
        end
        else if (load_tx)
        begin
            state_ff <= S_TX;
            tx_ff <= tx_next;
            sda_oe <= ~tx_next[7];
            bit_cnt_ff <= 4'h0;
            rd_cnt_ff <= ~rd_cnt_ff;
            if (rd_blk_ff)
                ptr_ff <= ptr_inc;
        end
        else
        begin
            case (state_ff)
                S_RX:
                begin
                    if (scl_rise)
                    begin
                        sh_ff <= {sh_ff[6:0], sda};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        state_ff <= ack_ok ? S_ACK : S_IDLE;
                        sda_oe <= ack_ok;
                        if (byte_idx_ff != 2'h3)
                            byte_idx_ff <= byte_idx_ff + 2'h1;
                        if (byte_idx_ff == 2'h0)
                        begin
                            gc_ff <= is_gc;
                            reading_ff <= sh_ff[0] && addr_hit;
                            rd_reg_ff <= sh_ff[0] && (op_ff == OP_RD_SINGLE
                                         || op_ff == OP_RD_BLOCK);
                            rd_blk_ff <= op_ff == OP_RD_BLOCK;
                            rd_cnt_ff <= 1'b0;
                            if (addr_hit)
                                op_ff <= OP_NONE;
                        end
                        else if (gc_ff)
                            op_ff <= OP_NONE;
                        else if (byte_idx_ff == 2'h1)
                            op_ff <= op_valid ? sh_ff : OP_NONE;
                        else if (byte_idx_ff == 2'h2)
                            ptr_ff <= sh_ff[7:6] != 2'h0 ? 7'h40
                                      : {1'b0, sh_ff[5:0]};
                        else if (op_ff == OP_WR_BLOCK)
                            ptr_ff <= ptr_inc;
                        else
                            op_ff <= OP_NONE;
                    end
                end
                S_ACK:
                begin
                    if (scl_fall)
                    begin
                        state_ff <= S_RX;
                        sda_oe <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                    end
                end
                S_TX:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        if (bit_cnt_ff == 4'h7)
                        begin
                            state_ff <= S_TACK;
                            sda_oe <= 1'b0;
                        end
                        else
                        begin
                            tx_ff <= {tx_ff[6:0], 1'b0};
                            sda_oe <= ~tx_ff[6];
                        end
                    end
                end
                S_TACK:
                begin
                    if (scl_rise)
                        nack_ff <= sda;
                    else if (scl_fall)
                        state_ff <= S_IDLE;
                end
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // resets requested over the link or by software
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soft_rst_ff <= 1'b0;
            readdr_ff <= 1'b0;
        end
        else
        begin
            soft_rst_ff <= (byte_done && gc_ff && byte_idx_ff == 2'h1 &&
                            sh_ff == GC_RESET) ||
                           (wr_hit && ptr_ff[5:0] == A_GENCFG &&
                            wr_val[B_SELF_RST]);
            readdr_ff <= byte_done && gc_ff && byte_idx_ff == 2'h1 &&
                         sh_ff == GC_READDR;
        end
    end

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    wire [2:0] cur_ch = conv_ff.ch;
    wire [7:0] th_hi = regs_ff[{1'b1, cur_ch, OFS_HIGH_TH}];
    wire [7:0] th_lo = regs_ff[{1'b1, cur_ch, OFS_LOW_TH}];
    wire cmp_en = conv_res.done && conv_mode != CM_MANUAL;
    wire cmp_hit = cmp_en && (conv_res.data[11:4] > th_hi ||
                              conv_res.data[11:4] < th_lo);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 64; i++)
                regs_ff[i] <= rst_val(i);
        end
        else if (soft_rst_ff)
        begin
            for (int i = 0; i < 64; i++)
                regs_ff[i] <= rst_val(i);
        end
        else
        begin
            if (wr_hit)
            begin
                if (ptr_ff[5:0] == A_STATUS)
                    regs_ff[A_STATUS] <= regs_ff[A_STATUS] & ~sh_ff;
                else
                    regs_ff[ptr_ff[5:0]] <= wr_val;
            end
            // a hit in the same cycle as a clear keeps the flag set
            if (cmp_hit)
                regs_ff[A_EVT_FLAG][cur_ch] <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // conversion control and sequencer
    // ---------------------------------------------------------------
    // the timer only runs once armed by a host start; clearing run disarms
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_ff <= '0;
            seq_ch_ff <= 3'h0;
            arm_ff <= 1'b0;
            tmr_ff <= 8'h00;
            result_ff <= 12'h000;
            alert_ff <= 1'b0;
        end
        else
        begin
            conv_ff.start <= 1'b0;
            conv_ff.ch <= seq_on ? seq_ch_ff : regs_ff[A_MANUAL_CH][2:0];
            if (conv_res.done)
                result_ff <= conv_res.data;
            if (conv_res.done && seq_on && run)
                seq_ch_ff <= nxt_chan(seq_ch_ff, seq_mask);
            if (conv_mode == CM_MANUAL || !run)
            begin
                arm_ff <= 1'b0;
                conv_ff.start <= host_start && conv_mode == CM_MANUAL;
            end
            else if (!arm_ff)
            begin
                arm_ff <= host_start;
                conv_ff.start <= host_start;
                tmr_ff <= 8'h00;
            end
            else if (tmr_ff == 8'(conv_mode == CM_TURBO ? TURBO_CYC - 1
                                                      : AUTO_CYC - 1))
            begin
                tmr_ff <= 8'h00;
                conv_ff.start <= 1'b1;
            end
            else
                tmr_ff <= tmr_ff + 8'h01;
            alert_ff <= |(regs_ff[A_EVT_FLAG] & regs_ff[A_ALERT_SEL]);
        end
    end

    assign conv_req = conv_ff;
    assign alert_out = alert_ff;
    assign sda_out = sda_out_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    pwr_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
        soft_rst_ff |=> regs_ff[A_STATUS][B_PWR_CYCLE] && !run)
        else $error("reset did not set flag or clear run");
    addr_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        byte_done && byte_idx_ff == 2'h0 && !addr_ok_ff && !is_gc
        |=> state_ff == S_IDLE && !sda_oe)
        else $error("address acked before evaluation");
    seq_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
        conv_res.done && seq_on && run && seq_mask != 8'h00
        |=> seq_mask[seq_ch_ff])
        else $error("sequencer left the channel mask");
    seq_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        conv_res.done && !run |=> $stable(seq_ch_ff))
        else $error("sequencer moved while stopped");
    turbo_nodata_a: assert property (@(posedge mclk) disable iff (!rst_n)
        load_tx && conv_rd && conv_mode == CM_TURBO |=> tx_ff == 8'h00)
        else $error("turbo mode returned data");
    man_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        host_start && conv_mode == CM_MANUAL |=> conv_ff.start)
        else $error("manual conversion not started");
    auto_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        conv_ff.start && !$past(host_start) |-> $past(arm_ff) && $past(run))
        else $error("timer start without arming");
    alert_path_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cmp_hit && regs_ff[A_ALERT_SEL][cur_ch] && !soft_rst_ff
        |=> ##1 alert_ff)
        else $error("threshold hit did not raise alert");
    bad_op_a: assert property (@(posedge mclk) disable iff (!rst_n)
        byte_done && !gc_ff && byte_idx_ff == 2'h1 && !op_valid
        |=> op_ff == OP_NONE ##1 !wr_hit)
        else $error("unknown opcode was accepted");

endmodule

// File: tb/adcic_host.sv
`timescale 1ns/1ps
module adcic_host (
    // clock
    input wire logic mclk,
    // bus pins, sda pulled up on the wire
    input wire logic sda,
    output logic scl,
    output logic sda_lo
);
    initial {scl, sda_lo} = 2'b10;
    task automatic hp(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // start (f=0) or stop (f=1); start from scl low is a restart
    task automatic cond(input logic f, input logic l);
        hp(2);
        sda_lo <= f;
        hp(2);
        scl <= 1'b1;
        hp(4);
        sda_lo <= l;
        hp(4);
        scl <= f;
    endtask
    // nine clocks; the ninth carries our ack when reading
    task automatic xfer(input logic [7:0] d, input logic ak,
                        output logic [7:0] q, output logic a);
        logic [8:0] w;
        logic [8:0] r;
        w = {d, ~ak};
        for (int i = 8; i >= 0; i--)
        begin
            hp(2);
            sda_lo <= ~w[i];
            hp(2);
            scl <= 1'b1;
            hp(4);
            r[i] = sda;
            scl <= 1'b0;
        end
        {q, a} = {r[8:1], ~r[0]};
    endtask
endmodule

// File: tb/adcic_top_tb.sv
`timescale 1ns/1ps
module adcic_top_tb
    import adcic_pkg::*;
;
    localparam logic [6:0] DEV = 7'h10 + 7'h05;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda_lo, sda_oe, sda_out, alert_out, ak;
    wire sda = ~(sda_lo | (sda_oe & ~sda_out));
    adcic_conv_t conv_req;
    adcic_res_t conv_res = '0;
    logic [2:0] dp = '0;
    logic [2:0] pch = '0;
    logic [2:0] strap = 3'h5;
    logic [7:0] q;
    logic [7:0] got [4];
    int gap = 0, starts = 0, exp_gap = 0, s0;
    int fail_count = 0, comparisons = 0;

    always #4 mclk = ~mclk;

    adcic_top adcic_top_inst (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap(strap), .conv_req(conv_req), .conv_res(conv_res),
        .alert_out(alert_out));
    adcic_host adcic_host_inst (.mclk(mclk), .sda(sda), .scl(scl),
        .sda_lo(sda_lo));

    // ----------------
    // access tasks
    // ----------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e)
        begin
            $display("ERROR %0t got %h want %h", $time, g, e);
            fail_count++;
        end
    endtask
    task automatic tx(input logic [7:0] d);
        adcic_host_inst.xfer(d, 1'b0, q, ak);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] ra,
                       input logic [23:0] d, input int nd);
        adcic_host_inst.cond(1'b0, 1'b1);
        tx({DEV, 1'b0});
        chk({7'h0, ak}, 8'h01);
        tx(op);
        tx(ra);
        for (int i = 0; i < nd; i++)
            tx(d[23 - 8 * i -: 8]);
        adcic_host_inst.cond(1'b1, 1'b0);
    endtask
    // we nack the last byte read
    task automatic rdf(input int n);
        adcic_host_inst.cond(1'b0, 1'b1);
        tx({DEV, 1'b1});
        for (int i = 0; i < n; i++)
            adcic_host_inst.xfer(8'hFF, i < n - 1, got[i], ak);
        adcic_host_inst.cond(1'b1, 1'b0);
    endtask
    task automatic rreg(input logic [7:0] ra, input logic [7:0] e);
        cmd(OP_RD_SINGLE, ra, '0, 0);
        rdf(1);
        chk(got[0], e);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------
    // converter stand-in: result four cycles after start
    // ----------------
    always @(posedge mclk)
    begin
        dp <= {dp[1:0], conv_req.start};
        conv_res <= '{dp[2], 12'h800};
        gap <= conv_req.start ? 0 : gap + 1;
        if (conv_req.start)
        begin
            starts <= starts + 1;
            if (exp_gap != 0)
            begin
                chk(8'(gap + 1), 8'(exp_gap));
                chk({5'h0, conv_req.ch}, pch == 3'h1 ? 8'h03 : 8'h01);
            end
            pch <= conv_req.ch;
        end
    end

    // ----------------
    // tests
    // ----------------
    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (10) @(posedge mclk);
        cmd(OP_RD_SINGLE, A_STATUS, '0, 0);
        rdf(2);
        chk(got[0], RST_STATUS);
        chk(got[1], RST_STATUS);
        cmd(OP_WR_SINGLE, A_STATUS, 24'h01_0000, 1);
        cmd(OP_WR_SINGLE, A_MANUAL_CH, 24'h05_0000, 1);
        cmd(OP_SET_BITS, A_MANUAL_CH, 24'h02_0000, 1);
        cmd(OP_CLR_BITS, A_MANUAL_CH, 24'h05_0000, 1);
        cmd(8'h38, A_MANUAL_CH, 24'hFF_0000, 1);
        cmd(OP_WR_BLOCK, A_SEQ_MASK, 24'h0A_FF02, 3);
        cmd(OP_RD_BLOCK, A_MANUAL_CH, '0, 0);
        rdf(4);
        for (int i = 0; i < 4; i++)
            chk(got[i], 8'(32'h020A_0002 >> (24 - 8 * i)));
        // a start frame hands out the previous result, so read a second pair
        s0 = starts;
        rdf(2);
        chk(got[1], 8'h02);
        rdf(2);
        chk(got[0], 8'h80);
        chk(8'(starts - s0), 8'h04);
        // thresholds and mode only while the run bit is clear
        cmd(OP_WR_SINGLE, 8'h25, 24'h10_0000, 1);
        cmd(OP_WR_SINGLE, A_OPMODE, 24'h20_0000, 1);
        cmd(OP_WR_SINGLE, A_SEQCFG, 24'h11_0000, 1);
        rdf(1);
        repeat (140) @(posedge mclk);
        exp_gap <= AUTO_CYC;
        repeat (400) @(posedge mclk);
        exp_gap <= 0;
        chk({7'h0, alert_out}, 8'h01);
        cmd(OP_CLR_BITS, A_SEQCFG, 24'h10_0000, 1);
        s0 = starts;
        repeat (300) @(posedge mclk);
        chk(8'(starts - s0), 8'h00);
        rreg(A_EVT_FLAG, 8'h02);
        cmd(OP_WR_SINGLE, A_OPMODE, 24'h40_0000, 1);
        cmd(OP_SET_BITS, A_SEQCFG, 24'h10_0000, 1);
        rdf(1);
        chk(got[0], 8'h00);
        repeat (60) @(posedge mclk);
        exp_gap <= TURBO_CYC;
        repeat (200) @(posedge mclk);
        exp_gap <= 0;
        cmd(OP_CLR_BITS, A_SEQCFG, 24'h10_0000, 1);
        // move the strap and have the address taken again
        strap <= 3'h6;
        adcic_host_inst.cond(1'b0, 1'b1);
        tx(GC_ADDR);
        tx(GC_READDR);
        adcic_host_inst.cond(1'b0, 1'b1);
        tx({DEV, 1'b0});
        chk({7'h0, ak}, 8'h00);
        adcic_host_inst.cond(1'b0, 1'b1);
        tx({DEV + 7'h01, 1'b0});
        chk({7'h0, ak}, 8'h01);
        adcic_host_inst.cond(1'b1, 1'b0);
        strap <= 3'h5;
        adcic_host_inst.cond(1'b0, 1'b1);
        tx(GC_ADDR);
        chk({7'h0, ak}, 8'h01);
        tx(GC_RESET);
        adcic_host_inst.cond(1'b1, 1'b0);
        rreg(A_OPMODE, 8'h00);
        rreg(A_STATUS, RST_STATUS);
        cmd(OP_SET_BITS, A_SEQCFG, 24'h10_0000, 1);
        cmd(OP_WR_SINGLE, A_STATUS, 24'h01_0000, 1);
        cmd(OP_WR_SINGLE, A_GENCFG, 24'h01_0000, 1);
        rreg(A_SEQCFG, 8'h00);
        rreg(A_STATUS, RST_STATUS);
        end_of_test();
    end

    // about 11k cycles expected
    initial
    begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        end_of_test();
    end
endmodule
